// ### src/load_regs_defines.svh
`ifndef LOAD_REGS_DEFINES_SVH
`define LOAD_REGS_DEFINES_SVH

// Function codes
`define FC_READ_HOLD        8'h03
`define FC_WRITE_SINGLE     8'h06
`define FC_WRITE_MULTI      8'h10

// Exception codes
`define EXC_NONE            8'h00
`define EXC_BAD_FUNC        8'h01
`define EXC_BAD_ADDR        8'h02
`define EXC_BAD_VALUE       8'h03

// Register counts
`define CNT_FLOAT           8'h02
`define CNT_SELECT          8'h01

// Write and read-back offsets
`define OFS_FALL_I_WR       16'h5090
`define OFS_FALL_I_RD       16'h50A0
`define OFS_FALL_V_WR       16'h50B0
`define OFS_FALL_V_RD       16'h50C0
`define OFS_FALL_P_WR       16'h50D0
`define OFS_FALL_P_RD       16'h50E0
`define OFS_FALL_R_WR       16'h50F0
`define OFS_FALL_R_RD       16'h5100
`define OFS_RANGE_WR        16'h6010
`define OFS_RANGE_RD        16'h6020
`define OFS_REGSEL_WR       16'h6030
`define OFS_REGSEL_RD       16'h6040
`define OFS_WAVE_WR         16'h7010
`define OFS_WAVE_RD         16'h7020
`define OFS_SIN_AMP_WR      16'h7030
`define OFS_SIN_AMP_RD      16'h7040
`define OFS_SIN_OFS_WR      16'h7050
`define OFS_SIN_OFS_RD      16'h7060
`define OFS_SIN_PRD_WR      16'h7070
`define OFS_SIN_PRD_RD      16'h7080
`define OFS_SQ_LO_WR        16'h7090
`define OFS_SQ_LO_RD        16'h70A0
`define OFS_SQ_HI_WR        16'h70B0
`define OFS_SQ_HI_RD        16'h70C0
`define OFS_SQ_LOD_WR       16'h70D0
`define OFS_SQ_LOD_RD       16'h70E0
`define OFS_SQ_HID_WR       16'h70F0
`define OFS_SQ_HID_RD       16'h7100
`define OFS_STEP_LO_WR      16'h7110
`define OFS_STEP_LO_RD      16'h7120
`define OFS_STEP_HI_WR      16'h7130
`define OFS_STEP_HI_RD      16'h7140
`define OFS_SOURCE_WR       16'h80A0
`define OFS_SOURCE_RD       16'h80B0
`define OFS_QUERY_STEP      16'h0010

// Float limits (IEEE-754 single)
`define F_ZERO              32'h00000000
`define F_SLEW_MIN          32'h3F800000
`define F_PERIOD_MIN        32'h40000000
`define F_PERIOD_MAX        32'h477DE800
`define F_EXP_BIAS          8'h7F
`define F_EXP_MS_TOP        8'h8E
`define F_EXP_SHIFT_BASE    8'h96

// Keyword codes on the request
`define KEY_NONE            2'h0
`define KEY_MIN             2'h1
`define KEY_MAX             2'h2

// Selector and dwell reset values
`define RST_RANGE           16'h0000
`define RST_REGSEL          16'h0001
`define RST_WAVE            16'h0000
`define RST_SOURCE          16'h0000
`define RST_DWELL_MS        16'h0002

// Timing
`define CLK_PERIOD_NS       40
`define MS_IN_NS            1000000

`endif

// ### src/load_regs_pkg.sv
package load_regs_pkg;

   typedef enum logic [3:0] {
      FI_FALL_I,
      FI_FALL_V,
      FI_FALL_P,
      FI_FALL_R,
      FI_SIN_AMP,
      FI_SIN_OFS,
      FI_SIN_PRD,
      FI_SQ_LO,
      FI_SQ_HI,
      FI_SQ_LOD,
      FI_SQ_HID,
      FI_STEP_LO,
      FI_STEP_HI,
      FI_NONE
   } float_idx_type;

   typedef enum logic [1:0] {
      LIM_SLEW,
      LIM_LEVEL,
      LIM_PERIOD
   } limit_class_type;

   typedef enum logic [15:0] {
      REG_CURRENT     = 16'h0001,
      REG_VOLTAGE     = 16'h0002,
      REG_POWER       = 16'h0003,
      REG_RESISTANCE  = 16'h0004,
      REG_VARIABLE_RESISTOR = 16'h0005,
      REG_SHUNT_REGULATOR   = 16'h0006
   } regulation_type;

   typedef enum logic [15:0] {
      WAVE_SINE   = 16'h0000,
      WAVE_SQUARE = 16'h0001,
      WAVE_STEP   = 16'h0002,
      WAVE_RAMP   = 16'h0003
   } waveform_type;

   typedef enum logic [15:0] {
      SRC_LOCAL    = 16'h0000,
      SRC_FUNC_GEN = 16'h0001,
      SRC_ANALOG   = 16'h0002
   } source_type;

endpackage

// ### src/load_slew_and_waveform_regs.sv
`timescale 1ns/10ps
`include "load_regs_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RQ1: Falling current slew, write and query addresses
// RQ2: Falling voltage slew, write and query addresses
// RQ3: Falling power slew, write and query addresses
// RQ4: Falling resistance slew, write and query addresses
// RQ5: Max keyword fastest, min keyword slowest
// RQ6: Clamp slew into range, minimum one
// RQ7: Floats written code 0x10, read count two
// RQ8: Selectors single register, code 0x06
// RQ9: Range select, 0 low, 1 high
// RQ10: Regulation selector decodes values one to six
// RQ11: Waveform selector 0..3, active from generator
// RQ12: Hold sinusoid amplitude
// RQ13: Hold sinusoid midline offset
// RQ14: Hold sinusoid period in milliseconds
// RQ15: Periods clamp between 2 and 65000 ms
// RQ16: Hold square low and high levels
// RQ17: Hold square low dwell time
// RQ18: Hold square high dwell time
// RQ19: Hold step low level
// RQ20: Levels clamp from zero to model maximum
// RQ21: Source selector 0 local, 1 generator, 2 analog
// RQ22: Hold step high level
// RQ23: Square alternates levels for dwell times
// RQ24: Query returns last accepted value
module load_slew_and_waveform_regs #(
   parameter logic [31:0] SLEW_MAX_F    = 32'h42C80000,
   parameter logic [31:0] LEVEL_MAX_F   = 32'h42C80000,
   parameter bit          HAS_RANGE     = 1'b1,
   parameter int          CYCLES_PER_MS = `MS_IN_NS / `CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Register request
   input  wire logic        reqValid,
   input  wire logic [7:0]  reqFunc,
   input  wire logic [15:0] reqAddr,
   input  wire logic [7:0]  reqCount,
   input  wire logic [31:0] reqData,
   input  wire logic [1:0]  reqKeyword,
   // Register answer
   output logic             rspValid_r,
   output logic [7:0]       rspExc_r,
   output logic [31:0]      rspData_r,
   // Settings toward the regulator
   output logic [31:0]      activeFallSlew_r,
   output logic             rangeHigh_r,
   output logic [15:0]      regulation_select_r,
   output logic [15:0]      waveform_select_r,
   output logic [15:0]      source_select_r,
   // Function generator
   output logic             genActive_r,
   output logic             squareHigh_r,
   output logic [31:0]      genLevel_r
);

   localparam int TICK_W = $clog2(CYCLES_PER_MS + 1);

   typedef enum logic [1:0] {
      GEN_IDLE,
      GEN_LOW,
      GEN_HIGH
   } gen_state_type;

   ////////////////////////////////////////////////////////////////////////////
   // Address and value helpers

   function automatic load_regs_pkg::float_idx_type floatWrIdx(input logic [15:0] a);
      case (a)
         `OFS_FALL_I_WR:  floatWrIdx = load_regs_pkg::FI_FALL_I;
         `OFS_FALL_V_WR:  floatWrIdx = load_regs_pkg::FI_FALL_V;
         `OFS_FALL_P_WR:  floatWrIdx = load_regs_pkg::FI_FALL_P;
         `OFS_FALL_R_WR:  floatWrIdx = load_regs_pkg::FI_FALL_R;
         `OFS_SIN_AMP_WR: floatWrIdx = load_regs_pkg::FI_SIN_AMP;
         `OFS_SIN_OFS_WR: floatWrIdx = load_regs_pkg::FI_SIN_OFS;
         `OFS_SIN_PRD_WR: floatWrIdx = load_regs_pkg::FI_SIN_PRD;
         `OFS_SQ_LO_WR:   floatWrIdx = load_regs_pkg::FI_SQ_LO;
         `OFS_SQ_HI_WR:   floatWrIdx = load_regs_pkg::FI_SQ_HI;
         `OFS_SQ_LOD_WR:  floatWrIdx = load_regs_pkg::FI_SQ_LOD;
         `OFS_SQ_HID_WR:  floatWrIdx = load_regs_pkg::FI_SQ_HID;
         `OFS_STEP_LO_WR: floatWrIdx = load_regs_pkg::FI_STEP_LO;
         `OFS_STEP_HI_WR: floatWrIdx = load_regs_pkg::FI_STEP_HI;
         default:         floatWrIdx = load_regs_pkg::FI_NONE;
      endcase
   endfunction

   // Every float query sits one step above its write; a write address never decodes here
   function automatic load_regs_pkg::float_idx_type floatRdIdx(input logic [15:0] a);
      floatRdIdx = floatWrIdx(a - `OFS_QUERY_STEP);
   endfunction

   function automatic load_regs_pkg::limit_class_type limitOf(
      input load_regs_pkg::float_idx_type i);
      case (i)
         load_regs_pkg::FI_FALL_I, load_regs_pkg::FI_FALL_V,
         load_regs_pkg::FI_FALL_P, load_regs_pkg::FI_FALL_R:
            limitOf = load_regs_pkg::LIM_SLEW;
         load_regs_pkg::FI_SIN_PRD, load_regs_pkg::FI_SQ_LOD, load_regs_pkg::FI_SQ_HID:
            limitOf = load_regs_pkg::LIM_PERIOD;
         default:
            limitOf = load_regs_pkg::LIM_LEVEL;
      endcase
   endfunction

   // Positive IEEE floats order like unsigned integers; any negative value is below the floor
   function automatic logic [31:0] acceptFloat(input logic [31:0] v, input logic [1:0] key,
                                               input logic [31:0] lo, input logic [31:0] hi);
      if (key == `KEY_MIN) begin
         acceptFloat = lo;                                  // RQ5
      end else if (key == `KEY_MAX) begin
         acceptFloat = hi;                                  // RQ5
      end else if (v[31] || v < lo) begin
         acceptFloat = lo;                                  // RQ6
      end else if (v > hi) begin
         acceptFloat = hi;                                  // RQ6
      end else begin
         acceptFloat = v;
      end
   endfunction

   // Truncates a clamped period float to whole milliseconds
   function automatic logic [15:0] floatToMs(input logic [31:0] f);
      logic [23:0] mant;
      logic [7:0]  shift;
      mant  = {1'b1, f[22:0]};
      shift = `F_EXP_SHIFT_BASE - f[30:23];
      if (f[31] || f[30:23] < `F_EXP_BIAS) begin
         floatToMs = 16'h0000;
      end else if (f[30:23] > `F_EXP_MS_TOP) begin
         floatToMs = 16'hFFFF;
      end else begin
         floatToMs = 16'(mant >> shift);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Request decode

   logic [31:0]                  floatReg_r [0:12];
   logic [15:0]                  sqLoMs_r;
   logic [15:0]                  sqHiMs_r;
   load_regs_pkg::float_idx_type wrIdx;
   load_regs_pkg::float_idx_type rdIdx;
   logic [31:0]                  loLim;
   logic [31:0]                  hiLim;
   logic [31:0]                  acceptVal;
   logic [7:0]                   exc;
   logic                         floatWrEn;
   logic                         selWrEn;
   logic                         selOk;

   assign wrIdx = floatWrIdx(reqAddr);
   assign rdIdx = floatRdIdx(reqAddr);

   always_comb begin
      case (limitOf(wrIdx))
         load_regs_pkg::LIM_SLEW: begin
            loLim = `F_SLEW_MIN;                            // RQ6
            hiLim = SLEW_MAX_F;
         end
         load_regs_pkg::LIM_PERIOD: begin
            loLim = `F_PERIOD_MIN;                          // RQ15
            hiLim = `F_PERIOD_MAX;
         end
         default: begin
            loLim = `F_ZERO;                                // RQ20
            hiLim = LEVEL_MAX_F;
         end
      endcase
   end

   assign acceptVal = acceptFloat(reqData, reqKeyword, loLim, hiLim);

   // Selector value check; range select is refused on variants without it
   always_comb begin
      case (reqAddr)
         `OFS_RANGE_WR:  selOk = HAS_RANGE && reqData[15:0] <= 16'h0001;          // RQ9
         `OFS_REGSEL_WR: selOk = reqData[15:0] >= 16'h0001 &&
                                 reqData[15:0] <= 16'h0006;                         // RQ10
         `OFS_WAVE_WR:   selOk = reqData[15:0] <= 16'h0003;                         // RQ11
         `OFS_SOURCE_WR: selOk = reqData[15:0] <= 16'h0002;                         // RQ21
         default:        selOk = 1'b0;
      endcase
   end

   logic isSelWr;
   logic isSelRd;
   assign isSelWr = reqAddr == `OFS_RANGE_WR || reqAddr == `OFS_REGSEL_WR ||
                    reqAddr == `OFS_WAVE_WR || reqAddr == `OFS_SOURCE_WR;
   assign isSelRd = reqAddr == `OFS_RANGE_RD || reqAddr == `OFS_REGSEL_RD ||
                    reqAddr == `OFS_WAVE_RD || reqAddr == `OFS_SOURCE_RD;

   always_comb begin
      exc = `EXC_NONE;
      case (reqFunc)
         `FC_WRITE_MULTI: begin
            if (wrIdx == load_regs_pkg::FI_NONE) begin
               exc = `EXC_BAD_ADDR;
            end else if (reqCount != `CNT_FLOAT) begin
               exc = `EXC_BAD_VALUE;                        // RQ7
            end
         end
         `FC_WRITE_SINGLE: begin
            if (!isSelWr) begin
               exc = `EXC_BAD_ADDR;
            end else if (!selOk) begin
               exc = `EXC_BAD_VALUE;                        // RQ8
            end
         end
         `FC_READ_HOLD: begin
            if (rdIdx != load_regs_pkg::FI_NONE) begin
               if (reqCount != `CNT_FLOAT) begin
                  exc = `EXC_BAD_VALUE;                     // RQ7
               end
            end else if (isSelRd) begin
               if (reqCount != `CNT_SELECT) begin
                  exc = `EXC_BAD_VALUE;                     // RQ8
               end
            end else begin
               exc = `EXC_BAD_ADDR;
            end
         end
         default: exc = `EXC_BAD_FUNC;
      endcase
   end

   assign floatWrEn = reqValid && reqFunc == `FC_WRITE_MULTI && exc == `EXC_NONE;
   assign selWrEn   = reqValid && reqFunc == `FC_WRITE_SINGLE && exc == `EXC_NONE;

   ////////////////////////////////////////////////////////////////////////////
   // Float settings; stored after clamping so the query shows the accepted value

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         for (int i = 0; i < 13; i++) begin
            floatReg_r[i] <= `F_ZERO;
         end
         floatReg_r[load_regs_pkg::FI_FALL_I] <= SLEW_MAX_F;
         floatReg_r[load_regs_pkg::FI_FALL_V] <= SLEW_MAX_F;
         floatReg_r[load_regs_pkg::FI_FALL_P] <= SLEW_MAX_F;
         floatReg_r[load_regs_pkg::FI_FALL_R] <= SLEW_MAX_F;
         floatReg_r[load_regs_pkg::FI_SIN_PRD] <= `F_PERIOD_MIN;
         floatReg_r[load_regs_pkg::FI_SQ_LOD]  <= `F_PERIOD_MIN;
         floatReg_r[load_regs_pkg::FI_SQ_HID]  <= `F_PERIOD_MIN;
      end else if (floatWrEn) begin
         floatReg_r[wrIdx] <= acceptVal;                    // RQ1 RQ2 RQ3 RQ4 RQ12 RQ13 RQ14 RQ16 RQ19 RQ22
      end
   end

   // Dwell counts kept as integers so the generator needs no float math
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sqLoMs_r <= `RST_DWELL_MS;
         sqHiMs_r <= `RST_DWELL_MS;
      end else if (floatWrEn && wrIdx == load_regs_pkg::FI_SQ_LOD) begin
         sqLoMs_r <= floatToMs(acceptVal);                  // RQ17
      end else if (floatWrEn && wrIdx == load_regs_pkg::FI_SQ_HID) begin
         sqHiMs_r <= floatToMs(acceptVal);                  // RQ18
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Selectors

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rangeHigh_r         <= 1'b0;
         regulation_select_r <= `RST_REGSEL;
         waveform_select_r   <= `RST_WAVE;
         source_select_r     <= `RST_SOURCE;
      end else if (selWrEn) begin
         case (reqAddr)
            `OFS_RANGE_WR:  rangeHigh_r         <= reqData[0];       // RQ9
            `OFS_REGSEL_WR: regulation_select_r <= reqData[15:0];    // RQ10
            `OFS_WAVE_WR:   waveform_select_r   <= reqData[15:0];    // RQ11
            `OFS_SOURCE_WR: source_select_r     <= reqData[15:0];    // RQ21
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answer, one cycle after the request

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rspValid_r <= 1'b0;
         rspExc_r   <= `EXC_NONE;
         rspData_r  <= 32'h00000000;
      end else begin
         rspValid_r <= reqValid;
         if (reqValid) begin
            rspExc_r  <= exc;
            rspData_r <= 32'h00000000;
            if (exc == `EXC_NONE && reqFunc == `FC_READ_HOLD) begin
               if (rdIdx != load_regs_pkg::FI_NONE) begin
                  rspData_r <= floatReg_r[rdIdx];           // RQ24
               end else begin
                  case (reqAddr)
                     `OFS_RANGE_RD:  rspData_r <= {31'h00000000, rangeHigh_r};
                     `OFS_REGSEL_RD: rspData_r <= {16'h0000, regulation_select_r};
                     `OFS_WAVE_RD:   rspData_r <= {16'h0000, waveform_select_r};
                     `OFS_SOURCE_RD: rspData_r <= {16'h0000, source_select_r};
                     default:        rspData_r <= 32'h00000000;
                  endcase
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slew handed to the regulator; only falling transitions use it

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         activeFallSlew_r <= SLEW_MAX_F;
      end else begin
         case (regulation_select_r)
            load_regs_pkg::REG_VOLTAGE:    activeFallSlew_r <= floatReg_r[load_regs_pkg::FI_FALL_V];
            load_regs_pkg::REG_POWER:      activeFallSlew_r <= floatReg_r[load_regs_pkg::FI_FALL_P];
            load_regs_pkg::REG_RESISTANCE: activeFallSlew_r <= floatReg_r[load_regs_pkg::FI_FALL_R];
            default:                       activeFallSlew_r <= floatReg_r[load_regs_pkg::FI_FALL_I];
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Millisecond tick and square generator

   logic [TICK_W-1:0] tickCnt_r;
   logic              msTick_r;
   logic [15:0]       dwellCnt_r;
   gen_state_type     genState_r;
   logic              genOn;
   logic              squareOn;

   assign genOn    = source_select_r == load_regs_pkg::SRC_FUNC_GEN;    // RQ11
   assign squareOn = genOn && waveform_select_r == load_regs_pkg::WAVE_SQUARE;

   always_ff @(posedge clk_sys) begin
      if (!rst_b || !squareOn) begin
         tickCnt_r <= '0;
         msTick_r  <= 1'b0;
      end else if (tickCnt_r == TICK_W'(CYCLES_PER_MS - 1)) begin
         tickCnt_r <= '0;
         msTick_r  <= 1'b1;
      end else begin
         tickCnt_r <= tickCnt_r + 1'b1;
         msTick_r  <= 1'b0;
      end
   end

   // New dwell values take effect at the next level change, never mid-dwell
   always_ff @(posedge clk_sys) begin
      if (!rst_b || !squareOn) begin
         genState_r <= GEN_IDLE;
         dwellCnt_r <= '0;
      end else begin
         case (genState_r)
            GEN_IDLE: begin
               genState_r <= GEN_LOW;
               dwellCnt_r <= sqLoMs_r;
            end
            GEN_LOW, GEN_HIGH: begin
               if (msTick_r && dwellCnt_r <= 16'h0001) begin
                  genState_r <= (genState_r == GEN_LOW) ? GEN_HIGH : GEN_LOW;   // RQ23
                  dwellCnt_r <= (genState_r == GEN_LOW) ? sqHiMs_r : sqLoMs_r;
               end else if (msTick_r) begin
                  dwellCnt_r <= dwellCnt_r - 1'b1;
               end
            end
            default: genState_r <= GEN_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         genActive_r  <= 1'b0;
         squareHigh_r <= 1'b0;
         genLevel_r   <= `F_ZERO;
      end else begin
         genActive_r  <= genOn;
         squareHigh_r <= genState_r == GEN_HIGH;
         if (!genOn) begin
            genLevel_r <= `F_ZERO;
         end else begin
            case (waveform_select_r)
               // Sinusoid shape is synthesised downstream; here only the midline
               load_regs_pkg::WAVE_SINE:   genLevel_r <= floatReg_r[load_regs_pkg::FI_SIN_OFS];
               load_regs_pkg::WAVE_SQUARE: genLevel_r <= (genState_r == GEN_HIGH) ?
                                             floatReg_r[load_regs_pkg::FI_SQ_HI] :
                                             floatReg_r[load_regs_pkg::FI_SQ_LO];   // RQ16
               load_regs_pkg::WAVE_STEP:   genLevel_r <= floatReg_r[load_regs_pkg::FI_STEP_LO];
               default:                    genLevel_r <= `F_ZERO;
            endcase
         end
      end
   end

endmodule // load_slew_and_waveform_regs

// ### tb/load_regs_props.sv
`timescale 1ns/10ps
module load_regs_props (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_b,
   // Request
   input wire logic        reqValid,
   input wire logic [7:0]  reqFunc,
   input wire logic [15:0] reqAddr,
   input wire logic [31:0] reqData,
   // Answer and settings
   input wire logic        rspValid_r,
   input wire logic [7:0]  rspExc_r,
   input wire logic        rangeHigh_r,
   input wire logic [15:0] regulation_select_r,
   input wire logic [15:0] source_select_r,
   input wire logic        genActive_r,
   input wire logic [31:0] genLevel_r
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic sel;
   assign sel = reqValid && reqFunc == 8'h06;
   // Level lags the source one stage
   sequence notGen;
      (source_select_r != 16'h0001) [*4];
   endsequence
   chk_answer_next: assert property (reqValid |=> rspValid_r)
      else $error("answer missing");
   chk_no_spurious: assert property (!reqValid |=> !rspValid_r)
      else $error("answer without request");
   chk_bad_func: assert property (reqValid && !(reqFunc inside {8'h03, 8'h06, 8'h10})
      |=> rspExc_r == 8'h01) else $error("unknown code accepted");
   chk_query_only: assert property (reqValid && reqFunc == 8'h03 && reqAddr == 16'h5090
      |=> rspExc_r == 8'h02) else $error("write address readable");
   chk_mode_refuse: assert property (sel && reqAddr == 16'h6030
      && (reqData[15:0] == 16'h0000 || reqData[15:0] > 16'h0006)
      |=> rspExc_r == 8'h03 && $stable(regulation_select_r)) else $error("bad mode taken");
   chk_range_write: assert property (sel && reqAddr == 16'h6010 && reqData[15:1] == 15'h0
      |=> rangeHigh_r == $past(reqData[0])) else $error("range not taken");
   chk_gen_follow: assert property (1'b1 |=> genActive_r == $past(source_select_r == 16'h0001))
      else $error("generator enable wrong");
   chk_level_idle: assert property (notGen |-> genLevel_r == 32'h0)
      else $error("level while not generating");
endmodule // load_regs_props
bind load_slew_and_waveform_regs load_regs_props load_regs_props_i (.*);

// ### tb/load_master_model.sv
`timescale 1ns/10ps
module load_master_model (
   // Clock
   input  wire logic        clk_sys,
   // Request
   output logic             reqValid,
   output logic [7:0]       reqFunc,
   output logic [15:0]      reqAddr,
   output logic [7:0]       reqCount,
   output logic [31:0]      reqData,
   output logic [1:0]       reqKeyword,
   // Answer
   input  wire logic        rspValid_r,
   input  wire logic [7:0]  rspExc_r,
   input  wire logic [31:0] rspData_r
);
   initial begin
      reqValid = 1'b0;
      {reqFunc, reqAddr, reqCount, reqData, reqKeyword} = '0;
   end
   // Released address and data lines inverted so stale data never passes
   task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [7:0] c,
      input logic [31:0] d, input logic [1:0] k, output logic [7:0] e, output logic [31:0] q);
      e = 8'hFF;
      q = '0;
      @(posedge clk_sys);
      {reqFunc, reqAddr, reqCount, reqData, reqKeyword} <= {f, a, c, d, k};
      reqValid <= 1'b1;
      @(posedge clk_sys);
      reqValid <= 1'b0;
      {reqAddr, reqData} <= ~{a, d};
      for (int i = 0; i < 4 && e === 8'hFF; i++) begin
         @(posedge clk_sys);
         if (rspValid_r === 1'b1) begin
            e = rspExc_r;
            q = rspData_r;
         end
      end
   endtask
endmodule // load_master_model

// ### tb/load_slew_and_waveform_regs_test.sv
`timescale 1ns/10ps
module load_slew_and_waveform_regs_test;
   localparam logic [31:0] MX = 32'h42C80000;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        reqValid, rspValid_r, rangeHigh_r, genActive_r, squareHigh_r;
   logic [7:0]  reqFunc, reqCount, rspExc_r;
   logic [1:0]  reqKeyword;
   logic [15:0] reqAddr, regulation_select_r, waveform_select_r, source_select_r;
   logic [31:0] reqData, rspData_r, activeFallSlew_r, genLevel_r;
   logic [15:0] slews [4] = '{16'h5090, 16'h50B0, 16'h50D0, 16'h50F0};
   logic [15:0] prds [3] = '{16'h7070, 16'h70D0, 16'h70F0};
   logic [15:0] lvls [6] = '{16'h7030, 16'h7050, 16'h7090, 16'h70B0, 16'h7110, 16'h7130};
   int          nFail = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          n;
   load_slew_and_waveform_regs #(.SLEW_MAX_F(MX), .LEVEL_MAX_F(MX), .HAS_RANGE(1'b1),
      .CYCLES_PER_MS(10)) load_slew_and_waveform_regs_i (.*);
   load_master_model load_master_model_i (.*);
   always #20 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrapUp;
      $display("comparisons %0d mismatches %0d", comparisons, nFail);
      if (nFail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [15:0] a, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         nFail++;
         $display("[FAIL] reg %h expected %h seen %h", a, x, g);
      end
   endtask
   // For reads d carries the expected data
   task automatic tx(input logic [7:0] f, input logic [15:0] a, input logic [7:0] c,
                     input logic [31:0] d, input logic [1:0] k, input logic [7:0] x);
      logic [7:0]  e;
      logic [31:0] q;
      load_master_model_i.xfer(f, a, c, d, k, e, q);
      chk(a, {24'h0, x}, {24'h0, e});
      if (f == 8'h03)
         chk(a, d, q);
   endtask
   task automatic pair(input logic [15:0] a, input logic [31:0] d, input logic [1:0] k,
                       input logic [31:0] q);
      tx(8'h10, a, 8'h02, d, k, 8'h00);
      tx(8'h03, a + 16'h0010, 8'h02, q, 2'h0, 8'h00);
   endtask
   task automatic sel(input logic [15:0] a, input logic [31:0] d, input logic [31:0] q,
                      input logic [7:0] x);
      tx(8'h06, a, 8'h01, d, 2'h0, x);
      tx(8'h03, a + 16'h0010, 8'h01, q, 2'h0, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         nFail++;
         wrapUp();
      end
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      foreach (slews[i]) begin
         pair(slews[i], 32'h40A00000, 2'h0, 32'h40A00000);
         pair(slews[i], 32'h3F000000, 2'h0, 32'h3F800000);
         pair(slews[i], 32'h43480000, 2'h0, MX);
         pair(slews[i], 32'h40A00000, 2'h1, 32'h3F800000);
         pair(slews[i], 32'h00000000, 2'h2, MX);
      end
      foreach (prds[i]) begin
         pair(prds[i], 32'h3F800000, 2'h0, 32'h40000000);
         pair(prds[i], 32'h4788B800, 2'h0, 32'h477DE800);
         pair(prds[i], 32'h40000000, 2'h2, 32'h477DE800);
         pair(prds[i], 32'h40400000, 2'h0, 32'h40400000);
      end
      foreach (lvls[i]) begin
         pair(lvls[i], 32'hBF800000, 2'h0, 32'h00000000);
         pair(lvls[i], 32'h00000000, 2'h2, MX);
         pair(lvls[i], 32'h40400000, 2'h0, 32'h40400000);
      end
      for (int m = 1; m <= 6; m++)
         sel(16'h6030, 32'(m), 32'(m), 8'h00);
      sel(16'h6030, 32'h7, 32'h6, 8'h03);
      for (int m = 0; m <= 3; m++)
         sel(16'h7010, 32'(m), 32'(m), 8'h00);
      sel(16'h7010, 32'h4, 32'h3, 8'h03);
      sel(16'h6010, 32'h1, 32'h1, 8'h00);
      chk(16'h6010, 32'h1, {31'h0, rangeHigh_r});
      sel(16'h6010, 32'h0, 32'h0, 8'h00);
      tx(8'h04, 16'h5090, 8'h02, 32'h0, 2'h0, 8'h01);
      tx(8'h03, 16'h5090, 8'h02, 32'h0, 2'h0, 8'h02);
      tx(8'h10, 16'h50B0, 8'h03, 32'h0, 2'h0, 8'h03);
      pair(16'h50B0, 32'h40E00000, 2'h0, 32'h40E00000);
      sel(16'h6030, 32'h2, 32'h2, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk(16'h50B0, 32'h40E00000, activeFallSlew_r);
      pair(16'h70B0, 32'h40A00000, 2'h0, 32'h40A00000);
      pair(16'h70D0, 32'h40000000, 2'h0, 32'h40000000);
      sel(16'h7010, 32'h1, 32'h1, 8'h00);
      sel(16'h80A0, 32'h1, 32'h1, 8'h00);
      chk(16'h80A0, 32'h1, {31'h0, genActive_r});
      for (n = 0; squareHigh_r !== 1'b1 && n < 200; n++)
         @(posedge clk_sys);
      chk(16'h70B0, 32'h40A00000, genLevel_r);
      for (n = 0; squareHigh_r === 1'b1 && n < 200; n++)
         @(posedge clk_sys);
      chk(16'h70F0, 32'd30, 32'(n));
      chk(16'h7090, 32'h40400000, genLevel_r);
      for (n = 0; squareHigh_r === 1'b0 && n < 200; n++)
         @(posedge clk_sys);
      chk(16'h70D0, 32'd20, 32'(n));
      sel(16'h7010, 32'h2, 32'h2, 8'h00);
      chk(16'h7110, 32'h40400000, genLevel_r);
      wrapUp();
   end
endmodule // load_slew_and_waveform_regs_test
